// File: logic/fosp_regs.vh
// Purpose: Constants for the flash option, security and protect block.
// Assumes: Word-aligned registers on a 32-bit classic Wishbone bus.
// Notes: Only definitions here; included by bare name.
`ifndef FOSP_REGS_VH
`define FOSP_REGS_VH

// ==========================================================
// Register word offsets (byte addresses)
`define FOSP_OFS_OPTIONS 4'h0
`define FOSP_OFS_CONFIG 4'h4
`define FOSP_OFS_PROTECT 4'h8
`define FOSP_OFS_STATUS 4'hC

// ==========================================================
// Field positions
`define FOSP_OPT_BACKDOOR_KEY_ENABLE_BIT 7
`define FOSP_OPT_NORED_BIT 6
`define FOSP_CFG_KEY_ACCESS_ENABLE_BIT 5
`define FOSP_PROT_DIS_BIT 0
`define FOSP_STS_SECURE_BIT 0
`define FOSP_STS_VIOL_BIT 1
`define FOSP_STS_KEYOK_BIT 2

// ==========================================================
// Masks, codes and reset values
`define FOSP_OPT_MASK 8'hC3
`define FOSP_CFG_MASK 8'hE0
`define FOSP_CFG_RESET 8'h00
`define FOSP_CFG_RESET_TOP 3'h0
`define FOSP_CFG_LSB 5
`define FOSP_CFG_HI 7
`define FOSP_OPT_SEC_HI 1
`define FOSP_PROT_SEL_HI 7
`define FOSP_PROT_SEL_LO 1
`define FOSP_SEC_UNSECURED 2'h2
`define FOSP_KEY_BASE 16'hFFB0
`define FOSP_KEY_HI 13'h1FF6
`define FOSP_KEY_BYTES 4'h8
`define FOSP_BLOCK_BITS 9
`define FOSP_LOW_ONES 9'h1FF

`endif

// File: logic/fosp_key_cmp.v
// Purpose: Backdoor key byte collector and comparator.
// Assumes: Bytes arrive one per write, ascending from the first slot.
// Notes: Any out-of-order or short entry spoils the attempt.
`timescale 1ns/100ps
`include "fosp_regs.vh"

module fosp_key_cmp (
    input wire clk_i,
    input wire rst_i,
    input wire wr_i,
    input wire [2:0] idx_i,
    input wire [7:0] data_i,
    input wire [63:0] key_i,
    input wire done_i,
    output reg match_o
);

    reg [3:0] cnt_ff;
    reg ok_ff;

    // Slot 0 sits in the low byte of the stored key
    function [7:0] key_byte;
        input [63:0] key;
        input [2:0] idx;
        begin
            key_byte = key[{idx, 3'h0} +: 8];
        end
    endfunction

    // ==========================================================
    // Collection and verdict
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= 4'h0;
            ok_ff <= 1'b1;
            match_o <= 1'b0;
        end else if (done_i) begin
            match_o <= ok_ff && (cnt_ff == `FOSP_KEY_BYTES);
            cnt_ff <= 4'h0;
            ok_ff <= 1'b1;
        end else begin
            match_o <= 1'b0;
            if (wr_i) begin
                // Ascending order only; a ninth byte spoils it
                if ((cnt_ff >= `FOSP_KEY_BYTES) ||
                    (idx_i != cnt_ff[2:0]) ||
                    (data_i != key_byte(key_i, idx_i))) begin
                    ok_ff <= 1'b0;
                end
                if (cnt_ff != 4'hF) begin
                    cnt_ff <= cnt_ff + 4'h1;
                end
            end
        end
    end

endmodule

// File: logic/fosp_prot_chk.v
// Purpose: Decides whether a flash address lies in the protected block.
// Assumes: Protected region runs from the boundary up to the top.
// Notes: Pure combinational; address width is a parameter.
`timescale 1ns/100ps
`include "fosp_regs.vh"

module fosp_prot_chk #(
    parameter ADDR_W = 16
) (
    input wire [ADDR_W-1:0] addr_i,
    input wire [6:0] select_i,
    input wire disable_i,
    output wire hit_o
);

    // ==========================================================
    // Boundary: last unprotected address is select:all-ones
    wire [ADDR_W-1:0] last_free;
    assign last_free = {select_i, `FOSP_LOW_ONES};
    assign hit_o = !disable_i && (addr_i > last_free);

endmodule

// File: logic/fosp_top.v
// Purpose: Flash options, configuration and protection registers,
//          with security state, backdoor key and protect checking.
// Assumes: Classic Wishbone slave, 25 MHz clk_i, synchronous rst_i.
//          All side ports come from logic on the same clock.
// Notes: Option and protect bytes are sampled while rst_i is high.
//        They must be stable on the last reset edge; a change after
//        release is not seen until the next reset.
//
// Notes on behaviour
// - Reset copies stored options byte into options
// - Options bits 5:2 read zero; writes ignored
// - Key enable gates backdoor unlock until reset
// - Only secure firmware may write key bytes
// - Redirect-disable bit one turns redirection off
// - Only security code 1:0 means unsecured
// - Secure state blocks unsecured memory access
// - Key match or blank check unsecures device
// - Config bits 7:5 writable; 4:0 read zero
// - Key access steers key-window writes to compare
// - Reset loads protection from stored protect byte
// - Protection ignores bus writes; debug writes update
// - Protect select sets unprotected region end
// - Erase or program into protected block rejected
// - Protect disable one leaves nothing protected
// - Clearing key access compares key, may unlock
// - Protected command ignored, sets write-one-clear flag
`timescale 1ns/100ps
`include "fosp_regs.vh"

module fosp_top #(
    parameter ADDR_W = 16
) (
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [3:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // Nonvolatile bytes from the flash array
    input wire [7:0] stored_options_byte_i,
    input wire [7:0] stored_protect_byte_i,
    input wire [63:0] stored_backdoor_key_i,
    // CPU writes into flash space
    input wire flash_wr_i,
    input wire [ADDR_W-1:0] flash_addr_i,
    input wire [7:0] flash_data_i,
    input wire flash_src_secure_i,
    output reg flash_cmd_wr_o,
    output reg [ADDR_W-1:0] flash_cmd_addr_o,
    output reg [7:0] flash_cmd_data_o,
    // Command registration from the command engine
    input wire cmd_launch_i,
    input wire [ADDR_W-1:0] cmd_target_i,
    input wire cmd_is_modify_i,
    input wire blank_ok_i,
    output reg cmd_go_o,
    // Background debug write of the protection register
    input wire bdm_prot_wr_i,
    input wire [7:0] bdm_prot_data_i,
    // Memory access gating
    input wire mem_req_i,
    input wire mem_src_secure_i,
    output wire mem_grant_o,
    output wire secure_o,
    output wire redirect_en_o
);

    // ==========================================================
    // State
    reg [1:0] opt_top_ff;
    reg [1:0] sec_ff;
    reg [2:0] cfg_ff;
    reg [7:0] prot_ff;
    reg viol_ff;
    // Sticky until reset; reported in status
    reg keyok_ff;

    wire wb_req;
    wire wb_wr;
    wire key_access_enable;
    wire backdoor_key_enable;
    wire key_win;
    wire key_wr;
    wire key_done;
    wire key_match;
    wire prot_hit;
    wire [7:0] opt_view;
    wire [7:0] cfg_view;
    wire cfg_wr;
    wire sts_wr;
    reg [7:0] sts_view;

    reg [7:0] nxt_rd;

    // ==========================================================
    // Register select, shared by every bus write decode
    function reg_hit;
        input [3:0] adr;
        input [3:0] ofs;
        begin
            reg_hit = (adr == ofs);
        end
    endfunction

    // ==========================================================
    // Decodes
    assign wb_req = cyc_i && stb_i && !ack_o;
    assign wb_wr = wb_req && we_i && sel_i[0];
    assign key_access_enable = cfg_ff[`FOSP_CFG_KEY_ACCESS_ENABLE_BIT - `FOSP_CFG_LSB];
    assign backdoor_key_enable = opt_top_ff[`FOSP_OPT_BACKDOOR_KEY_ENABLE_BIT - `FOSP_OPT_NORED_BIT];
    // Register writes that have side effects
    assign cfg_wr = wb_wr && reg_hit(adr_i, `FOSP_OFS_CONFIG);
    assign sts_wr = wb_wr && reg_hit(adr_i, `FOSP_OFS_STATUS);

    // Upper address bits select the eight key slots
    // The three low address bits then pick the slot
    assign key_win =
        (flash_addr_i[ADDR_W-1:3] == `FOSP_KEY_HI);

    // Non-secure sources never reach the comparator
    assign key_wr = flash_wr_i && key_win && key_access_enable && backdoor_key_enable &&
                    flash_src_secure_i;

    // Compare happens as software drops the key access bit
    // A rewrite of config that keeps key access set gives no verdict
    assign key_done = cfg_wr &&
                      key_access_enable &&
                      !dat_i[`FOSP_CFG_KEY_ACCESS_ENABLE_BIT];

    // ==========================================================
    // Submodules
    // Collects key bytes between entering and leaving key access
    fosp_key_cmp u_key (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(key_wr),
        .idx_i(flash_addr_i[2:0]),
        .data_i(flash_data_i),
        .key_i(stored_backdoor_key_i),
        .done_i(key_done),
        .match_o(key_match)
    );

    fosp_prot_chk #(
        .ADDR_W(ADDR_W)
    ) u_prot (
        .addr_i(cmd_target_i),
        .select_i(prot_ff[`FOSP_PROT_SEL_HI:`FOSP_PROT_SEL_LO]),
        .disable_i(prot_ff[`FOSP_PROT_DIS_BIT]),
        .hit_o(prot_hit)
    );

    // ==========================================================
    // Options and security state
    // A new stored value only takes effect through another reset
    always @(posedge clk_i) begin
        if (rst_i) begin
            opt_top_ff <= stored_options_byte_i[`FOSP_OPT_BACKDOOR_KEY_ENABLE_BIT:
                `FOSP_OPT_NORED_BIT];
            sec_ff <= stored_options_byte_i[`FOSP_OPT_SEC_HI:0];
            keyok_ff <= 1'b0;
        end else begin
            // The unlock also rewrites the code the options register
            // shows, so software reads back the state it runs in
            // Unlock holds until the next reset
            if ((key_match && backdoor_key_enable) || blank_ok_i) begin
                sec_ff <= `FOSP_SEC_UNSECURED;
            end
            if (key_match && backdoor_key_enable) begin
                keyok_ff <= 1'b1;
            end
        end
    end

    // Secure sources are never blocked; every other source,
    // except the debug port's protect writes, waits for an unlock
    assign secure_o = (sec_ff != `FOSP_SEC_UNSECURED);
    assign mem_grant_o = mem_req_i &&
                         (!secure_o || mem_src_secure_i);
    assign redirect_en_o =
        !opt_top_ff[`FOSP_OPT_NORED_BIT - `FOSP_OPT_NORED_BIT];

    // ==========================================================
    // Configuration register
    always @(posedge clk_i) begin
        if (rst_i) begin
            cfg_ff <= `FOSP_CFG_RESET_TOP;
        end else if (cfg_wr) begin
            // Low five bits are not stored, so they always read zero
            cfg_ff <= dat_i[`FOSP_CFG_HI:`FOSP_CFG_LSB];
        end
    end

    // ==========================================================
    // Protection register
    // Bus writes never land here; only the debug path may change it
    // A debug change lasts only until reset reloads the stored byte;
    // a lasting change needs that byte reprogrammed
    always @(posedge clk_i) begin
        if (rst_i) begin
            prot_ff <= stored_protect_byte_i;
        end else if (bdm_prot_wr_i) begin
            prot_ff <= bdm_prot_data_i;
        end
    end

    // ==========================================================
    // Command registration and protect violation flag
    always @(posedge clk_i) begin
        if (rst_i) begin
            cmd_go_o <= 1'b0;
            viol_ff <= 1'b0;
        end else begin
            // Only erase and program are screened; other commands pass
            cmd_go_o <= cmd_launch_i &&
                        !(cmd_is_modify_i && prot_hit);
            // A new violation wins over a same-cycle clear
            if (cmd_launch_i && cmd_is_modify_i && prot_hit) begin
                viol_ff <= 1'b1;
            end else if (sts_wr && dat_i[`FOSP_STS_VIOL_BIT]) begin
                viol_ff <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Flash-space writes toward the command engine
    // Key-window writes are swallowed while key access is set
    // Address and data still follow every write; without the strobe
    // the engine never acts on a swallowed key byte
    always @(posedge clk_i) begin
        if (rst_i) begin
            flash_cmd_wr_o <= 1'b0;
            flash_cmd_addr_o <= {ADDR_W{1'b0}};
            flash_cmd_data_o <= 8'h00;
        end else begin
            flash_cmd_wr_o <= flash_wr_i &&
                              !(key_win && key_access_enable);
            if (flash_wr_i) begin
                flash_cmd_addr_o <= flash_addr_i;
                flash_cmd_data_o <= flash_data_i;
            end
        end
    end

    // ==========================================================
    // Read views
    // Reads have no side effects, so polling never clears a flag
    assign opt_view = {opt_top_ff, 4'h0, sec_ff} &
                      `FOSP_OPT_MASK;
    assign cfg_view = {cfg_ff, 5'h00} & `FOSP_CFG_MASK;

    // Status bits are placed by name so the map lives in one header
    always @* begin
        sts_view = 8'h00;
        sts_view[`FOSP_STS_SECURE_BIT] = secure_o;
        sts_view[`FOSP_STS_VIOL_BIT] = viol_ff;
        sts_view[`FOSP_STS_KEYOK_BIT] = keyok_ff;
    end

    always @* begin
        case (adr_i)
            `FOSP_OFS_OPTIONS: begin
                nxt_rd = opt_view;
            end
            `FOSP_OFS_CONFIG: begin
                nxt_rd = cfg_view;
            end
            `FOSP_OFS_PROTECT: begin
                nxt_rd = prot_ff;
            end
            `FOSP_OFS_STATUS: begin
                nxt_rd = sts_view;
            end
            default: begin
                nxt_rd = 8'h00;
            end
        endcase
    end

    // ==========================================================
    // Wishbone answer: one wait state, unmapped reads give zero
    // The request is masked while ack stands, so a strobe held
    // through the ack edge is never taken twice. Read data reloads
    // only on reads and so stays steady across later writes.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= wb_req;
            if (wb_req && !we_i) begin
                dat_o <= {24'h000000, nxt_rd};
            end
        end
    end

endmodule

// File: testbench/fosp_top_properties.sv
// Purpose: Port-level properties of fosp_top.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to every fosp_top instance.
`timescale 1ns/100ps
module fosp_props (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    input wire [7:0] stored_options_byte_i,
    input wire flash_wr_i,
    input wire flash_cmd_wr_o,
    input wire cmd_launch_i,
    input wire cmd_is_modify_i,
    input wire blank_ok_i,
    input wire cmd_go_o,
    input wire mem_req_i,
    input wire mem_src_secure_i,
    input wire mem_grant_o,
    input wire secure_o,
    input wire redirect_en_o
);
// ==========================================================
// Properties
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
a_read_high: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
a_load_sec: assert property ($fell(rst_i) |->
    secure_o == ($past(stored_options_byte_i[1:0]) != 2'h2))
    else $error("security state not loaded");
a_load_redir: assert property ($fell(rst_i) |->
    redirect_en_o == !$past(stored_options_byte_i[6]))
    else $error("redirect state not loaded");
a_blank_unsec: assert property (blank_ok_i |=> !secure_o)
    else $error("blank check left device secure");
a_go_cause: assert property (cmd_go_o |-> $past(cmd_launch_i))
    else $error("command accepted without launch");
a_plain_go: assert property (
    cmd_launch_i && !cmd_is_modify_i |=> cmd_go_o)
    else $error("plain command refused");
a_fwd_cause: assert property (flash_cmd_wr_o |-> $past(flash_wr_i))
    else $error("forward without flash write");
a_mem_gate: assert property (mem_grant_o ==
    (mem_req_i && (!secure_o || mem_src_secure_i)))
    else $error("memory grant wrong");
endmodule

bind fosp_top fosp_props u_props (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .stored_options_byte_i(stored_options_byte_i),
    .flash_wr_i(flash_wr_i), .flash_cmd_wr_o(flash_cmd_wr_o),
    .cmd_launch_i(cmd_launch_i), .cmd_is_modify_i(cmd_is_modify_i),
    .blank_ok_i(blank_ok_i), .cmd_go_o(cmd_go_o),
    .mem_req_i(mem_req_i), .mem_src_secure_i(mem_src_secure_i),
    .mem_grant_o(mem_grant_o), .secure_o(secure_o),
    .redirect_en_o(redirect_en_o));

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for fosp_top.
// Assumes: Reads are checked by a monitor against queued notes.
// Notes: Nonvolatile bytes change only while reset is held.
`timescale 1ns/100ps
module tb_top;
logic clk_i, rst_i, cyc_i, stb_i, we_i, flash_wr_i, src, launch, modify;
logic blank_ok_i, bdm_wr, mem_req_i, mem_src;
logic [3:0] adr_i, sel_i;
logic [31:0] dat_i, dat_o;
logic [7:0] opt_nv, prot_nv, fdata, bdm_data, cmd_data, exp_q[$];
logic [63:0] key_nv;
logic [15:0] faddr, target, cmd_addr;
logic ack_o, fwd, go, grant, secure_o, redir;
integer bad_count, compares, seed, i, n;

fosp_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .stored_options_byte_i(opt_nv), .stored_protect_byte_i(prot_nv),
    .stored_backdoor_key_i(key_nv), .flash_wr_i(flash_wr_i),
    .flash_addr_i(faddr), .flash_data_i(fdata),
    .flash_src_secure_i(src), .flash_cmd_wr_o(fwd),
    .flash_cmd_addr_o(cmd_addr), .flash_cmd_data_o(cmd_data),
    .cmd_launch_i(launch), .cmd_target_i(target),
    .cmd_is_modify_i(modify), .blank_ok_i(blank_ok_i), .cmd_go_o(go),
    .bdm_prot_wr_i(bdm_wr), .bdm_prot_data_i(bdm_data),
    .mem_req_i(mem_req_i), .mem_src_secure_i(mem_src),
    .mem_grant_o(grant), .secure_o(secure_o), .redirect_en_o(redir));

// ==========================================================
// Checking and closing
task chk(input string what, input [31:0] seen, input [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("Error %s expected %h seen %h", what, exp, seen);
    end
endtask

task end_of_test;
    $display("compares %0d errors %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask

always @(posedge clk_i)
    if (ack_o === 1'b1 && we_i === 1'b0) begin
        if (exp_q.size() == 0)
            chk("read_extra", 1, 0);
        else
            chk("read_data", dat_o[7:0], exp_q.pop_front());
    end

// ==========================================================
// Drivers
task wb(input [3:0] a, input w, input [7:0] d);
    integer k;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    for (k = 0; k < 20 && ack_o !== 1'b1; k = k + 1)
        @(posedge clk_i);
    cyc_i <= 0;
    stb_i <= 0;
    if (k == 20) begin
        bad_count = bad_count + 1;
        end_of_test;
    end
endtask

task rd(input [3:0] a, input [7:0] e);
    exp_q.push_back(e);
    wb(a, 0, 8'h00);
endtask

task rst_nv(input [7:0] o);
    @(posedge clk_i);
    rst_i <= 1;
    opt_nv <= o;
    prot_nv <= $random(seed);
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
endtask

// Gaps of two idle edges keep key bytes off adjacent cycles
task fw(input [15:0] a, input [7:0] d, input s, input e);
    @(posedge clk_i);
    flash_wr_i <= 1;
    faddr <= a;
    fdata <= d;
    src <= s;
    @(posedge clk_i);
    flash_wr_i <= 0;
    @(posedge clk_i);
    chk("forward", fwd, e);
endtask

task cmd(input [15:0] t, input m, input e);
    @(posedge clk_i);
    launch <= 1;
    target <= t;
    modify <= m;
    @(posedge clk_i);
    launch <= 0;
    @(posedge clk_i);
    chk("cmd_go", go, e);
endtask

task key_try(input [7:0] o, input s, input ok);
    rst_nv(o);
    wb(4'h4, 1, 8'h20);
    for (n = 0; n < 8; n = n + 1)
        fw(16'hFFB0 + n, key_nv[8*n+:8], s, 0);
    wb(4'h4, 1, 8'h00);
    repeat (3) @(posedge clk_i);
    chk("key_unlock", secure_o, !ok);
    rd(4'hC, {5'h0, ok, 1'b0, !ok});
    rd(4'h0, ok ? ((o & 8'hC0) | 8'h02) : (o & 8'hC3));
endtask

// ==========================================================
// Main sequence
initial begin
    clk_i = 0;
    forever #20 clk_i = ~clk_i;
end

initial begin
    seed = 56;
    bad_count = 0;
    compares = 0;
    {rst_i, cyc_i, stb_i, we_i, flash_wr_i, src, launch, modify} = 8'h80;
    {blank_ok_i, bdm_wr, mem_req_i, mem_src, adr_i, dat_i} = 0;
    {opt_nv, prot_nv, fdata, bdm_data, faddr, target} = 0;
    sel_i = 4'hF;
    key_nv = {$random(seed), $random(seed)};
    for (i = 0; i < 4; i = i + 1) begin
        rst_nv(($random(seed) & 8'hFC) | i);
        rd(4'h0, opt_nv & 8'hC3);
        chk("secure", secure_o, i != 2);
        chk("redirect", redir, !opt_nv[6]);
        wb(4'h0, 1, ~opt_nv);
        rd(4'h0, opt_nv & 8'hC3);
        rd(4'h8, prot_nv);
        wb(4'h8, 1, ~prot_nv);
        rd(4'h8, prot_nv);
    end
    rd(4'h4, 8'h00);
    wb(4'h4, 1, 8'hFF);
    rd(4'h4, 8'hE0);
    rd(4'h2, 8'h00);
    mem_req_i <= 1;
    @(posedge clk_i);
    chk("grant", grant, 0);
    fw(16'h1234, 8'h5A, 1, 1);
    wb(4'h4, 1, 8'h00);
    fw(16'hFFB3, 8'hA5, 1, 1);
    chk("fwd_addr", cmd_addr, 16'hFFB3);
    chk("fwd_data", cmd_data, 8'hA5);
    bdm_wr <= 1;
    bdm_data <= 8'h80;
    @(posedge clk_i);
    bdm_wr <= 0;
    rd(4'h8, 8'h80);
    cmd(16'h8200, 1, 0);
    rd(4'hC, 8'h03);
    cmd(16'h81FF, 1, 1);
    cmd(16'h9000, 0, 1);
    wb(4'hC, 1, 8'h02);
    rd(4'hC, 8'h01);
    bdm_wr <= 1;
    bdm_data <= 8'h81;
    @(posedge clk_i);
    bdm_wr <= 0;
    cmd(16'hFFFF, 1, 1);
    blank_ok_i <= 1;
    @(posedge clk_i);
    blank_ok_i <= 0;
    @(posedge clk_i);
    chk("blank", secure_o, 0);
    chk("grant", grant, 1);
    key_try(8'h00, 1, 0);
    key_try(8'h80, 0, 0);
    key_try(8'h80, 1, 1);
    @(posedge clk_i);
    chk("queue_left", exp_q.size(), 0);
    end_of_test;
end
endmodule
